// File: hw/link_stats_cfg.svh
/*
  Constants for the link statistics block and its management controller.
  Assumes both ends and the bench include it by its bare name.
*/
// Overview of operation
// - Count good received packets, 48 bits, three parts
// - Good low read latches mid/high; read first
// - Good high read last, clears the counter
// - Count CRC errors, 48 bits, three parts
// - CRC low read freezes mid/high; read first
// - CRC high read last, clears the counter
// - Count transmitted packets, 48 bits, three parts
// - Transmit low read latches mid/high; read first
// - Transmit high read last, clears the counter
// - Count receive errors during data, 16 bits
// - Count receive errors during idle, 16 bits
// - Detect, correct, report polarity per pair
// - Pair 1 polarity valid after negotiation completes
// - Pairs 0, 2, 3 valid after link up
// - Report crossover of pairs 0/1 and 2/3
// - Read-only bits ignore writes
// - Write-only bits read unspecified, here zero
// - One-write-clears bits clear on written one
// - Any-write-clears bits clear on any write
// - Indirect access: address port, then read-data port
`ifndef LINK_STATS_CFG_SVH
`define LINK_STATS_CFG_SVH

// ----------------------------------------
// Primary register indexes
// ----------------------------------------
`define IDX_ADDR_PORT 5'h14
`define IDX_DATA_PORT 5'h15
`define IDX_MISC_CTL 5'h1b
`define IDX_WRAP_FLAGS 5'h1d

// ----------------------------------------
// Advanced register addresses
// ----------------------------------------
`define ADV_GOOD_LO 8'h00
`define ADV_GOOD_MID 8'h01
`define ADV_GOOD_HI 8'h02
`define ADV_CRC_LO 8'h03
`define ADV_CRC_MID 8'h04
`define ADV_CRC_HI 8'h05
`define ADV_TX_LO 8'h06
`define ADV_TX_MID 8'h07
`define ADV_TX_HI 8'h08
`define ADV_RXERR_DATA 8'h09
`define ADV_RXERR_IDLE 8'h0a
`define ADV_POLARITY 8'h0b
`define ADV_CROSSOVER 8'h0c

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BAD_ADDR_BIT 0
`define CLR_RXERR_BIT 15
`define CNT48_RST 48'h0000_0000_0000
`define CNT16_RST 16'h0000

// ----------------------------------------
// Controller APB map and command fields
// ----------------------------------------
`define APB_CMD 12'h000
`define APB_STATUS 12'h004
`define APB_RD0 12'h008
`define APB_RD1 12'h00c
`define APB_RD2 12'h010
`define CMD_GO 0
`define CMD_WR 1
`define CMD_IND 2
`define CMD_TRIPLE 3
`define CMD_IDX_LSB 4
`define CMD_WDATA_LSB 16

`endif

// File: hw/link_stats_pkg.sv
/*
  Types shared by the link statistics ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package link_stats_pkg;
  typedef enum logic [1:0] {
    CTL_IDLE = 2'b00,
    CTL_PRIM = 2'b01,
    CTL_ADDR = 2'b10,
    CTL_DATA = 2'b11
  } ctl_state_t;
  typedef logic [15:0] mgmt_word_t;
endpackage

// File: hw/stats_mgmt_if.sv
/*
  Register access link between management controller and statistics block.
  Assumes both ends share pclk; the link carries no clock itself.
*/
interface stats_mgmt_if;
  logic req;
  logic we;
  logic [4:0] idx;
  link_stats_pkg::mgmt_word_t wdata;
  link_stats_pkg::mgmt_word_t rdata;
  logic ack;
  modport dev (input req, input we, input idx, input wdata, output rdata, output ack);
  modport ctl (output req, output we, output idx, output wdata, input rdata, input ack);
endinterface

// File: hw/link_stats_dev.sv
/*
  Statistics counters, polarity and crossover status, indirect register access.
  Assumes line events are one-cycle pulses synchronous to pclk.
*/
// Chosen here: the register addresses; the APB slave port belongs to link_stats_ctl.
`include "link_stats_cfg.svh"

module link_stats_dev (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Management link
  stats_mgmt_if.dev mgmt,
  // Line events
  input wire logic good_pkt,
  input wire logic crc_err,
  input wire logic tx_pkt,
  input wire logic rx_err_data,
  input wire logic rx_err_idle,
  // Pair status
  input wire logic [3:0] pair_polarity_raw,
  input wire logic an_complete,
  input wire logic link_up,
  input wire logic [1:0] crossover_raw_a,
  input wire logic [1:0] crossover_raw_b,
  // Pair data
  input wire logic [3:0] pair_rx_bit,
  output logic [3:0] pair_rx_fixed
);

  // ----------------------------------------
  // Counter arithmetic
  // ----------------------------------------
  function automatic logic [47:0] next_count48(input logic [47:0] cur, input logic inc,
                                               input logic clr);
    next_count48 = clr ? {47'h0, inc} : cur + {47'h0, inc};
  endfunction

  function automatic logic [15:0] next_count16(input logic [15:0] cur, input logic inc,
                                               input logic clr);
    next_count16 = clr ? {15'h0, inc} : cur + {15'h0, inc};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [47:0] good_cnt;
  logic [47:0] crc_cnt;
  logic [47:0] tx_cnt;
  logic [31:0] good_hold;
  logic [31:0] crc_hold;
  logic [31:0] tx_hold;
  logic [15:0] rxerr_data_cnt;
  logic [15:0] rxerr_idle_cnt;
  logic [15:0] adv_addr;
  logic [4:0] wrap_flags;
  logic bad_addr;
  logic [3:0] pol_flipped;
  logic [1:0] crossover_state_pairs_a;
  logic [1:0] crossover_state_pairs_b;
  logic [15:0] rdata_q;
  logic ack_q;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  wire take = mgmt.req & ~mgmt.ack;
  wire wr = take & mgmt.we;
  wire rd = take & ~mgmt.we;
  wire rd_port = rd & (mgmt.idx == `IDX_DATA_PORT);
  wire wr_addr = wr & (mgmt.idx == `IDX_ADDR_PORT);
  wire wr_misc = wr & (mgmt.idx == `IDX_MISC_CTL);
  wire wr_wrap = wr & (mgmt.idx == `IDX_WRAP_FLAGS);
  wire [7:0] aa = adv_addr[7:0];
  wire adv_known = (adv_addr[15:8] == 8'h00) & (aa <= `ADV_CROSSOVER);
  wire rd_good_lo = rd_port & (adv_addr == {8'h00, `ADV_GOOD_LO});
  wire rd_good_hi = rd_port & (adv_addr == {8'h00, `ADV_GOOD_HI});
  wire rd_crc_lo = rd_port & (adv_addr == {8'h00, `ADV_CRC_LO});
  wire rd_crc_hi = rd_port & (adv_addr == {8'h00, `ADV_CRC_HI});
  wire rd_tx_lo = rd_port & (adv_addr == {8'h00, `ADV_TX_LO});
  wire rd_tx_hi = rd_port & (adv_addr == {8'h00, `ADV_TX_HI});
  wire clr_rxerr = wr_misc & mgmt.wdata[`CLR_RXERR_BIT];

  // ----------------------------------------
  // Pair status
  // ----------------------------------------
  wire pair0_polarity_flipped = pol_flipped[0] & link_up;
  wire pair1_polarity_flipped = pol_flipped[1] & an_complete;
  wire pair2_polarity_flipped = pol_flipped[2] & link_up;
  wire pair3_polarity_flipped = pol_flipped[3] & link_up;
  wire [3:0] polarity_word = {pair3_polarity_flipped, pair2_polarity_flipped,
                              pair1_polarity_flipped, pair0_polarity_flipped};

  // ----------------------------------------
  // Read selection
  // ----------------------------------------
  wire [15:0] adv_value =
    (aa == `ADV_GOOD_LO) ? good_cnt[15:0] :
    (aa == `ADV_GOOD_MID) ? good_hold[15:0] :
    (aa == `ADV_GOOD_HI) ? good_hold[31:16] :
    (aa == `ADV_CRC_LO) ? crc_cnt[15:0] :
    (aa == `ADV_CRC_MID) ? crc_hold[15:0] :
    (aa == `ADV_CRC_HI) ? crc_hold[31:16] :
    (aa == `ADV_TX_LO) ? tx_cnt[15:0] :
    (aa == `ADV_TX_MID) ? tx_hold[15:0] :
    (aa == `ADV_TX_HI) ? tx_hold[31:16] :
    (aa == `ADV_RXERR_DATA) ? rxerr_data_cnt :
    (aa == `ADV_RXERR_IDLE) ? rxerr_idle_cnt :
    (aa == `ADV_POLARITY) ? {12'h000, polarity_word} :
    (aa == `ADV_CROSSOVER) ? {12'h000, crossover_state_pairs_b, crossover_state_pairs_a} :
    16'h0000;
  wire [15:0] adv_read = adv_known ? adv_value : 16'h0000;
  // Write-only clear bit reads as zero
  wire [15:0] prim_value =
    (mgmt.idx == `IDX_ADDR_PORT) ? adv_addr :
    (mgmt.idx == `IDX_DATA_PORT) ? adv_read :
    (mgmt.idx == `IDX_MISC_CTL) ? {15'h0000, bad_addr} :
    (mgmt.idx == `IDX_WRAP_FLAGS) ? {11'h000, wrap_flags} :
    16'h0000;

  wire [4:0] wrap_set = {rx_err_idle & (&rxerr_idle_cnt), rx_err_data & (&rxerr_data_cnt),
                         tx_pkt & (&tx_cnt), crc_err & (&crc_cnt), good_pkt & (&good_cnt)};
  wire [4:0] wrap_clr = wr_wrap ? mgmt.wdata[4:0] : 5'h00;

  assign mgmt.rdata = rdata_q;
  assign mgmt.ack = ack_q;

  // ----------------------------------------
  // Management response
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
      adv_addr <= 16'h0000;
    end else begin
      ack_q <= take;
      if (rd) begin
        rdata_q <= prim_value;
      end
      if (wr_addr) begin
        adv_addr <= mgmt.wdata;
      end
    end
  end

  // ----------------------------------------
  // 48-bit counters and latches
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good_cnt <= `CNT48_RST;
      crc_cnt <= `CNT48_RST;
      tx_cnt <= `CNT48_RST;
      good_hold <= 32'h0000_0000;
      crc_hold <= 32'h0000_0000;
      tx_hold <= 32'h0000_0000;
    end else begin
      good_cnt <= next_count48(good_cnt, good_pkt, rd_good_hi);
      crc_cnt <= next_count48(crc_cnt, crc_err, rd_crc_hi);
      tx_cnt <= next_count48(tx_cnt, tx_pkt, rd_tx_hi);
      if (rd_good_lo) begin
        good_hold <= good_cnt[47:16];
      end
      if (rd_crc_lo) begin
        crc_hold <= crc_cnt[47:16];
      end
      if (rd_tx_lo) begin
        tx_hold <= tx_cnt[47:16];
      end
    end
  end

  // ----------------------------------------
  // 16-bit counters and flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxerr_data_cnt <= `CNT16_RST;
      rxerr_idle_cnt <= `CNT16_RST;
      wrap_flags <= 5'h00;
      bad_addr <= 1'b0;
    end else begin
      rxerr_data_cnt <= next_count16(rxerr_data_cnt, rx_err_data, clr_rxerr);
      rxerr_idle_cnt <= next_count16(rxerr_idle_cnt, rx_err_idle, clr_rxerr);
      wrap_flags <= wrap_set | (wrap_flags & ~wrap_clr);
      bad_addr <= (rd_port & ~adv_known) | (bad_addr & ~wr_misc);
    end
  end

  // ----------------------------------------
  // Polarity and crossover status
  // ----------------------------------------
  // Data port and status registers have no write path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_flipped <= 4'h0;
      pair_rx_fixed <= 4'h0;
      crossover_state_pairs_a <= 2'h0;
      crossover_state_pairs_b <= 2'h0;
    end else begin
      pol_flipped <= pair_polarity_raw;
      pair_rx_fixed <= pair_rx_bit ^ pair_polarity_raw;
      crossover_state_pairs_a <= crossover_raw_a;
      crossover_state_pairs_b <= crossover_raw_b;
    end
  end

endmodule

// File: hw/link_stats_ctl.sv
/*
  Management controller: APB slave that runs primary and indirect accesses.
  Assumes the statistics block answers each request with a one-cycle ack.
*/
`include "link_stats_cfg.svh"

module link_stats_ctl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Management link
  stats_mgmt_if.ctl mgmt
);

  link_stats_pkg::ctl_state_t state;
  logic req_q;
  logic we_q;
  logic [4:0] idx_q;
  logic [15:0] wdata_q;
  logic [15:0] base;
  logic triple;
  logic [1:0] step;
  logic done;
  logic [15:0] rd_word [0:2];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire busy = (state != link_stats_pkg::CTL_IDLE);
  wire hit = (paddr == `APB_CMD) | (paddr == `APB_STATUS) | (paddr == `APB_RD0) |
             (paddr == `APB_RD1) | (paddr == `APB_RD2);
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire start = access & pwrite & (paddr == `APB_CMD) & pwdata[`CMD_GO] & ~busy;
  wire start_ind = pwdata[`CMD_IND];
  wire last_step = ~triple | (step == 2'd2);
  wire [1:0] step_up = step + 2'd1;
  wire [31:0] read_mux =
    (paddr == `APB_STATUS) ? {30'h0000_0000, done, busy} :
    (paddr == `APB_RD0) ? {16'h0000, rd_word[0]} :
    (paddr == `APB_RD1) ? {16'h0000, rd_word[1]} :
    (paddr == `APB_RD2) ? {16'h0000, rd_word[2]} :
    32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign mgmt.req = req_q;
  assign mgmt.we = we_q;
  assign mgmt.idx = idx_q;
  assign mgmt.wdata = wdata_q;

  // ----------------------------------------
  // APB read data
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= read_mux;
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= link_stats_pkg::CTL_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      idx_q <= 5'h00;
      wdata_q <= 16'h0000;
      base <= 16'h0000;
      triple <= 1'b0;
      step <= 2'd0;
      done <= 1'b0;
      rd_word[0] <= 16'h0000;
      rd_word[1] <= 16'h0000;
      rd_word[2] <= 16'h0000;
    end else begin
      case (state)
        link_stats_pkg::CTL_IDLE: begin
          if (start) begin
            done <= 1'b0;
            req_q <= 1'b1;
            step <= 2'd0;
            base <= pwdata[`CMD_WDATA_LSB +: 16];
            wdata_q <= pwdata[`CMD_WDATA_LSB +: 16];
            triple <= start_ind & pwdata[`CMD_TRIPLE];
            if (start_ind) begin
              state <= link_stats_pkg::CTL_ADDR;
              idx_q <= `IDX_ADDR_PORT;
              we_q <= 1'b1;
            end else begin
              state <= link_stats_pkg::CTL_PRIM;
              idx_q <= pwdata[`CMD_IDX_LSB +: 5];
              we_q <= pwdata[`CMD_WR];
            end
          end
        end
        link_stats_pkg::CTL_PRIM: begin
          if (mgmt.ack) begin
            if (!we_q) begin
              rd_word[0] <= mgmt.rdata;
            end
            req_q <= 1'b0;
            done <= 1'b1;
            state <= link_stats_pkg::CTL_IDLE;
          end
        end
        link_stats_pkg::CTL_ADDR: begin
          if (mgmt.ack) begin
            idx_q <= `IDX_DATA_PORT;
            we_q <= 1'b0;
            state <= link_stats_pkg::CTL_DATA;
          end
        end
        link_stats_pkg::CTL_DATA: begin
          if (mgmt.ack) begin
            rd_word[step] <= mgmt.rdata;
            if (last_step) begin
              req_q <= 1'b0;
              done <= 1'b1;
              state <= link_stats_pkg::CTL_IDLE;
            end else begin
              // Low, mid, high in that order
              step <= step_up;
              idx_q <= `IDX_ADDR_PORT;
              we_q <= 1'b1;
              wdata_q <= base + {14'h0000, step_up};
              state <= link_stats_pkg::CTL_ADDR;
            end
          end
        end
        default: begin
          state <= link_stats_pkg::CTL_IDLE;
          req_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: verif/link_stats_chk.sv
/*
  Checker on the link between the management controller and the statistics block.
  Assumes one clock domain and the link signals brought in as plain inputs.
*/
`include "link_stats_cfg.svh"

module link_stats_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Management link
  input wire logic req,
  input wire logic we,
  input wire logic [4:0] idx,
  input wire link_stats_pkg::mgmt_word_t wdata,
  input wire link_stats_pkg::mgmt_word_t rdata,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_addr_wr;
    ack && we && idx == `IDX_ADDR_PORT;
  endsequence
  sequence s_data_rd;
    ##[1:2] (req && !we && idx == `IDX_DATA_PORT) ##1 ack;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ack_next;
    req && !ack |=> ack;
  endproperty
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  property p_ack_cause;
    ack |-> $past(req) && !$past(ack);
  endproperty
  property p_req_hold;
    req && !ack |=> req && $stable({we, idx, wdata});
  endproperty
  property p_rdata_hold;
    !(req && !ack && !we) |=> $stable(rdata);
  endproperty
  property p_indirect;
    s_addr_wr |-> s_data_rd;
  endproperty
  property p_wo_zero;
    ack && !we && idx == `IDX_MISC_CTL |-> !rdata[`CLR_RXERR_BIT];
  endproperty
  property p_unlisted;
    ack && !we && idx == 5'h00 |-> rdata == 16'h0000;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  a_indirect: assert property (p_indirect) else $error("no data read");
  a_wo_zero: assert property (p_wo_zero) else $error("write-only bit read");
  a_unlisted: assert property (p_unlisted) else $error("unlisted not zero");
endmodule

// File: verif/link_stats_counters_tb.sv
/*
  Bench for the statistics block and its controller joined by the link.
  Assumes the design files and the config header are compiled first.
*/
`include "link_stats_cfg.svh"

module link_stats_counters_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] ev;
  logic [3:0] pol_raw;
  logic an_ok;
  logic lnk;
  logic [3:0] xo;
  logic [3:0] rx_bit;
  logic [3:0] rx_fixed;
  logic [33:0] exp_q[$];
  logic [33:0] mon_e;
  logic [31:0] last_rd;
  logic [47:0] cnt;
  int miscompares;
  int n_checks;
  int cyc;
  stats_mgmt_if mgmt_if();
  // ----------------------------------------
  // Design and checker
  // ----------------------------------------
  link_stats_dev u_link_stats_dev (.pclk(pclk), .presetn(presetn), .mgmt(mgmt_if),
    .good_pkt(ev[0]), .crc_err(ev[1]), .tx_pkt(ev[2]), .rx_err_data(ev[3]),
    .rx_err_idle(ev[4]), .pair_polarity_raw(pol_raw), .an_complete(an_ok), .link_up(lnk),
    .crossover_raw_a(xo[1:0]), .crossover_raw_b(xo[3:2]), .pair_rx_bit(rx_bit),
    .pair_rx_fixed(rx_fixed));
  link_stats_ctl u_link_stats_ctl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mgmt(mgmt_if));
  link_stats_chk u_link_stats_chk (.pclk(pclk), .presetn(presetn), .req(mgmt_if.req),
    .we(mgmt_if.we), .idx(mgmt_if.idx), .wdata(mgmt_if.wdata), .rdata(mgmt_if.rdata),
    .ack(mgmt_if.ack));
  // ----------------------------------------
  // Clock, timeout, monitor
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      end_sim();
    end
  end
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      last_rd = prdata;
      if (mon_e[33]) chk({pslverr, prdata}, mon_e[32:0]);
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [31:0] cmdw(input logic w, input logic i, input logic t,
                                       input logic [4:0] x, input logic [15:0] d);
    cmdw = 32'h0000_0000;
    cmdw[`CMD_GO] = 1'b1;
    cmdw[`CMD_WR] = w;
    cmdw[`CMD_IND] = i;
    cmdw[`CMD_TRIPLE] = t;
    cmdw[`CMD_IDX_LSB +: 5] = x;
    cmdw[`CMD_WDATA_LSB +: 16] = d;
  endfunction
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [33:0] e);
    if (!w) exp_q.push_back(e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    apb(a, 1'b0, 32'h0000_0000, {2'b10, v});
  endtask
  task automatic run(input logic [31:0] c);
    apb(`APB_CMD, 1'b1, c, 34'h0_0000_0000);
    do apb(`APB_STATUS, 1'b0, 32'h0000_0000, 34'h0_0000_0000);
    while (last_rd[1:0] !== 2'b10);
  endtask
  task automatic rd3(input logic [7:0] b, input logic [47:0] v);
    run(cmdw(1'b0, 1'b1, 1'b1, 5'h00, {8'h00, b}));
    rd(`APB_RD0, {16'h0000, v[15:0]});
    rd(`APB_RD1, {16'h0000, v[31:16]});
    rd(`APB_RD2, {16'h0000, v[47:32]});
  endtask
  task automatic rd1(input logic [7:0] b, input logic [15:0] v);
    run(cmdw(1'b0, 1'b1, 1'b0, 5'h00, {8'h00, b}));
    rd(`APB_RD0, {16'h0000, v});
  endtask
  task automatic pw(input logic [4:0] x, input logic [15:0] d);
    run(cmdw(1'b1, 1'b0, 1'b0, x, d));
  endtask
  task automatic pr(input logic [4:0] x, input logic [15:0] v);
    run(cmdw(1'b0, 1'b0, 1'b0, x, 16'h0000));
    rd(`APB_RD0, {16'h0000, v});
  endtask
  task automatic pulse(input logic [4:0] m, input int n);
    ev <= m;
    repeat (n) @(posedge pclk);
    ev <= 5'h00;
    @(posedge pclk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, pol_raw, an_ok, lnk, xo, rx_bit} = '0;
    {miscompares, n_checks, cyc} = '0;
    last_rd = 32'h0000_0000;
    presetn = 1'b0;
    void'($urandom(32'hdb67_94ed));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      rd3(8'(3 * i), 48'h0);
      cnt = 48'($urandom_range(40, 1));
      pulse(5'(1 << i), int'(cnt));
      rd3(8'(3 * i), cnt);
      rd3(8'(3 * i), 48'h0);
      pulse(5'(1 << i), 3);
      rd1(8'(3 * i), 16'h0003);
      pulse(5'(1 << i), 2);
      rd1(8'(3 * i + 2), 16'h0000);
      rd3(8'(3 * i), 48'h0);
    end
    pulse(5'b01000, 65536);
    rd1(8'h09, 16'h0000);
    pr(5'h1d, 16'h0008);
    pw(5'h1d, 16'hfff7);
    pr(5'h1d, 16'h0008);
    pw(5'h1d, 16'h0008);
    pr(5'h1d, 16'h0000);
    cnt = 48'($urandom_range(40, 1));
    pulse(5'b11000, int'(cnt));
    rd1(8'h09, cnt[15:0]);
    rd1(8'h0a, cnt[15:0]);
    pw(5'h1b, 16'h8000);
    rd1(8'h09, 16'h0000);
    rd1(8'h0a, 16'h0000);
    pr(5'h1b, 16'h0000);
    rd1(8'h3f, 16'h0000);
    pr(5'h14, 16'h003f);
    pr(5'h1b, 16'h0001);
    pw(5'h1b, 16'h0000);
    pr(5'h1b, 16'h0000);
    rd1(8'h0a, 16'h0000);
    pw(5'h15, 16'hffff);
    pr(5'h15, 16'h0000);
    pr(5'h00, 16'h0000);
    apb(12'hffc, 1'b0, 32'h0000_0000, {2'b11, 32'h0000_0000});
    for (int k = 0; k < 4; k++) begin
      pol_raw <= 4'($urandom());
      xo <= 4'($urandom());
      rx_bit <= 4'($urandom());
      {lnk, an_ok} <= 2'(k);
      repeat (2) @(posedge pclk);
      chk({29'h0, rx_fixed}, {29'h0, rx_bit ^ pol_raw});
      rd1(8'h0b, {12'h000, pol_raw & {lnk, lnk, an_ok, lnk}});
      rd1(8'h0c, {12'h000, xo});
    end
    pulse(5'b11111, 5);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd3(8'h00, 48'h0);
    rd3(8'h03, 48'h0);
    rd3(8'h06, 48'h0);
    rd1(8'h09, 16'h0000);
    rd1(8'h0a, 16'h0000);
    end_sim();
  end
endmodule
